// ---- pkg/cdr_pkg.sv ----
// Shared constants and carrier types of the recovery control registers
package cdr_pkg;

  // ==========================================================
  // Register offsets on the serial management port
  localparam logic [7:0] ADDR_FREQ_LOW = 8'h00;
  localparam logic [7:0] ADDR_FREQ_MID = 8'h01;
  localparam logic [7:0] ADDR_FREQ_HIGH = 8'h02;
  localparam logic [7:0] ADDR_RATE = 8'h03;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_CTRL_A = 8'h08;
  localparam logic [7:0] ADDR_CTRL_B = 8'h09;
  localparam logic [7:0] ADDR_CTRL_C = 8'h11;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // Field positions
  localparam int A_LOCK_REF = 0;
  localparam int A_MEASURE = 1;
  localparam int A_RATIO_LO = 2;
  localparam int A_RATIO_HI = 5;
  localparam int A_BAND_LO = 6;
  localparam int A_BAND_HI = 7;
  localparam int B_CLR_MEAS = 3;
  localparam int B_SYS_RESET = 5;
  localparam int B_CLR_LOCK = 6;
  localparam int B_LOCK_PIN_LATCHED = 7;
  localparam int C_MUTE_EITHER = 1;
  localparam int C_LOSS_ACTIVE_LOW = 2;
  localparam logic [3:0] RATIO_EXP_MAX = 4'h8;

  // ==========================================================
  // Lock detector thresholds in ppm: 1000 and 250
  localparam logic [15:0] LOCK_LOST_PPM = 16'h03e8;
  localparam logic [15:0] RELOCK_PPM = 16'h00fa;

  // ==========================================================
  // Serial port
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h60;
  localparam int SLAVE_ADDR_PIN_BIT = 5;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    PH_ADDR, PH_ADDR_ACK, PH_REG, PH_REG_ACK,
    PH_WDATA, PH_WACK, PH_RDATA, PH_RACK
  } link_phase_e;

  // ==========================================================
  // Carriers to and from the recovery core
  typedef struct packed {
    logic mute;
    logic signal_loss;
    logic meas_done;
    logic [8:0] rate_code;
    logic [22:0] freq_count;
    logic [15:0] ppm_error;
  } core_in_s;

  typedef struct packed {
    logic [1:0] ref_band;
    logic [3:0] ratio_exp;
    logic lock_to_ref;
    logic meas_start;
    logic lock_lost;
    logic signal_absent;
    logic clk_out_en;
    logic data_out_en;
  } core_out_s;

endpackage

// ---- hw/sync2.sv ----
// Two-flop level synchroniser of configurable width
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s s;
  sync_s next_s;

  if (WIDTH < 1)
  begin : g_check
    $error("sync2 WIDTH must be at least 1");
  end

  always_comb
  begin
    next_s.meta = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.stable;
endmodule

// ---- hw/event_sync.sv ----
// Toggle-to-pulse crossing of one event between clock domains
`timescale 1ns/1ns
module event_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Event
  input wire logic tgl,
  output logic pulse
);
  typedef struct packed {
    logic meta;
    logic stable;
    logic seen;
  } tsync_s;

  tsync_s s;
  tsync_s next_s;

  always_comb
  begin
    next_s.meta = tgl;
    next_s.stable = s.meta;
    next_s.seen = s.stable;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // Only the second and third flops are compared
  assign pulse = s.stable ^ s.seen;
endmodule

// ---- hw/cdr_control_status_registers.sv ----
// Control and status registers of the recovery receiver, serial port
//
// Summary of operation
// - Writable control registers reset to 0x00
// - Flag D5 shows signal loss live
// - Flag D4 latches loss of lock until cleared
// - Flag D3 shows live acquiring state
// - Writing control A D1 starts rate measurement
// - Flag D2 is 1 once measurement completes
// - Nine-bit rate code split over 0x3/D0
// - Control A D0 picks data or reference lock
// - Control A D7:D6 give reference band
// - Control A D5:D2 give ratio exponent n
// - Control B D7 picks live or latched pin
// - Write 1 then 0 clears latched flag
// - Write 1 then 0 to B D5 resets
// - Control C D2 sets signal-loss pin polarity
// - Control C D1 picks muting style
// - Mute pin high quiets data, and clock too unless control C D1 is set
// - Lock lost above 1000, regained within 250 ppm
`timescale 1ns/1ns
module cdr_control_status_registers
  import cdr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
  // System clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Serial management port
  input wire logic SCK,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic SADDR5,
  // Recovery core
  input wire core_in_s CORE_IN,
  output core_out_s CORE_OUT
);

  // ==========================================================
  // State of the serial clock domain
  typedef struct packed {
    link_phase_e phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic read;
  } frame_s;

  // Survives repeated starts; only device reset clears it
  typedef struct packed {
    logic [7:0] ptr;
    logic wr_tgl;
    logic rd_tgl;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } session_s;

  // ==========================================================
  // State of the system clock domain
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic lock_lost;
    logic lock_latched;
    logic measuring;
    logic meas_done;
    logic done_prev;
    logic srst;
    logic sda_prev;
    logic frame_hold;
    logic [8:0] rate_code;
    logic [22:0] freq;
    logic [7:0] rd_byte;
    core_out_s out;
  } core_s;

  localparam core_s CORE_RESET = '{
    ctrl_a: CTRL_RESET,
    ctrl_b: CTRL_RESET,
    ctrl_c: CTRL_RESET,
    default: '0
  };

  frame_s frame;
  frame_s next_frame;
  session_s sess;
  session_s next_sess;
  core_s r;
  core_s next_r;
  logic frame_rst_n;
  logic sda_drive;
  logic next_sda_drive;
  logic addr_pin;
  logic [6:0] slave_addr;
  logic [7:0] byte_in;
  logic scl_s;
  logic sda_s;
  core_in_s ain;
  logic wr_pulse;
  logic rd_pulse;
  logic start;
  logic stop;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic meas_go;
  logic clr_lock;
  logic clr_meas;
  logic lock_event;
  logic done_rise;
  logic [7:0] rd_val;
  logic [7:0] flags;

  // ==========================================================
  // Crossings
  sync2 #(
    .WIDTH(1)
  ) addr_pin_sync (
    .clk(SCK),
    .rst_n(RESETN),
    .d(SADDR5),
    .q(addr_pin)
  );

  sync2 #(
    .WIDTH(2)
  ) bus_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .d({SCK, SDA_IN}),
    .q({scl_s, sda_s})
  );

  // Multi-bit core words are assumed slow against the clock
  sync2 #(
    .WIDTH($bits(core_in_s))
  ) core_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .d(CORE_IN),
    .q(ain)
  );

  event_sync wr_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .tgl(sess.wr_tgl),
    .pulse(wr_pulse)
  );

  event_sync rd_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .tgl(sess.rd_tgl),
    .pulse(rd_pulse)
  );

  // ==========================================================
  // Serial engine on the port's own clock
  // Start or stop briefly resets the frame; the clock is still then
  assign frame_rst_n = RESETN & ~r.frame_hold;

  always_comb
  begin
    slave_addr = SLAVE_ADDR;
    slave_addr[SLAVE_ADDR_PIN_BIT] = addr_pin;
  end

  // Data is taken on the rising clock, where the protocol keeps it still
  assign byte_in = {frame.shift[6:0], SDA_IN};

  always_comb
  begin
    next_frame = frame;
    next_sess = sess;
    unique case (frame.phase)
      PH_ADDR, PH_REG, PH_WDATA:
      begin
        next_frame.shift = byte_in;
        next_frame.bit_cnt = frame.bit_cnt + 3'h1;
        if (frame.bit_cnt == LAST_BIT)
        begin
          if (frame.phase == PH_REG)
            next_frame.phase = PH_REG_ACK;
          else if (frame.phase == PH_WDATA)
          begin
            next_frame.phase = PH_WACK;
            next_sess.wr_addr = sess.ptr;
            next_sess.wr_data = byte_in;
            next_sess.wr_tgl = ~sess.wr_tgl;
            next_sess.ptr = sess.ptr + 8'h01;
            next_sess.rd_tgl = ~sess.rd_tgl;
          end
          else if (byte_in[7:1] == slave_addr)
          begin
            next_frame.read = SDA_IN;
            next_frame.phase = PH_ADDR_ACK;
          end
          else
            next_frame.phase = PH_RACK;
        end
      end
      PH_ADDR_ACK:
      begin
        if (frame.read)
        begin
          next_frame.phase = PH_RDATA;
          next_frame.shift = r.rd_byte;
          next_sess.ptr = sess.ptr + 8'h01;
          next_sess.rd_tgl = ~sess.rd_tgl;
        end
        else
          next_frame.phase = PH_REG;
      end
      PH_REG_ACK:
      begin
        next_frame.phase = PH_WDATA;
        next_sess.ptr = frame.shift;
        next_sess.rd_tgl = ~sess.rd_tgl;
      end
      PH_WACK:
        next_frame.phase = PH_WDATA;
      PH_RDATA:
      begin
        next_frame.shift = {frame.shift[6:0], 1'b0};
        next_frame.bit_cnt = frame.bit_cnt + 3'h1;
        if (frame.bit_cnt == LAST_BIT)
        begin
          next_frame.phase = PH_RACK;
          next_frame.read = 1'b1;
        end
      end
      PH_RACK:
      begin
        // Master ack fetches the next byte; also the idle sink
        if (frame.read && !SDA_IN)
        begin
          next_frame.phase = PH_RDATA;
          next_frame.shift = r.rd_byte;
          next_sess.ptr = sess.ptr + 8'h01;
          next_sess.rd_tgl = ~sess.rd_tgl;
        end
        else
          next_frame.read = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    unique case (frame.phase)
      PH_ADDR_ACK, PH_REG_ACK, PH_WACK:
        next_sda_drive = 1'b1;
      PH_RDATA:
        next_sda_drive = ~frame.shift[7];
      default:
        next_sda_drive = 1'b0;
    endcase
  end

  always_ff @(posedge SCK or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      frame <= '{phase: PH_ADDR, default: '0};
    else
      frame <= next_frame;
  end

  always_ff @(posedge SCK or negedge RESETN)
  begin
    if (!RESETN)
      sess <= '0;
    else
      sess <= next_sess;
  end

  // Drive changes on the falling clock so it never mimics start or stop
  always_ff @(negedge SCK or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      sda_drive <= 1'b0;
    else
      sda_drive <= next_sda_drive;
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_drive;

  // ==========================================================
  // Register bank on the system clock
  always_comb
  begin
    start = scl_s & r.sda_prev & ~sda_s;
    stop = scl_s & ~r.sda_prev & sda_s;
    wr_a = wr_pulse && sess.wr_addr == ADDR_CTRL_A;
    wr_b = wr_pulse && sess.wr_addr == ADDR_CTRL_B;
    wr_c = wr_pulse && sess.wr_addr == ADDR_CTRL_C;
    meas_go = wr_a & sess.wr_data[A_MEASURE];
    clr_lock = wr_b & r.ctrl_b[B_CLR_LOCK] & ~sess.wr_data[B_CLR_LOCK];
    clr_meas = wr_b & r.ctrl_b[B_CLR_MEAS] & ~sess.wr_data[B_CLR_MEAS];
    if (r.lock_lost)
      lock_event = 1'b0;
    else
      lock_event = ain.ppm_error > LOCK_LOST_PPM;
    done_rise = ain.meas_done & ~r.done_prev;
    flags = {2'b00, ain.signal_loss, r.lock_latched, r.lock_lost,
      r.meas_done, 1'b0, r.rate_code[0]};
    unique case (sess.ptr)
      ADDR_FREQ_LOW:
        rd_val = r.freq[7:0];
      ADDR_FREQ_MID:
        rd_val = r.freq[15:8];
      ADDR_FREQ_HIGH:
        rd_val = {1'b0, r.freq[22:16]};
      ADDR_RATE:
        rd_val = r.rate_code[8:1];
      ADDR_FLAGS:
        rd_val = flags;
      // Control registers are write-only and read as zero
      default:
        rd_val = 8'h00;
    endcase
  end

  always_comb
  begin
    next_r = r;
    next_r.sda_prev = sda_s;
    next_r.frame_hold = start | stop;
    next_r.done_prev = ain.meas_done;
    if (r.lock_lost)
      next_r.lock_lost = ain.ppm_error > RELOCK_PPM;
    else
      next_r.lock_lost = lock_event;
    if (wr_a)
      next_r.ctrl_a = sess.wr_data;
    if (wr_b)
      next_r.ctrl_b = sess.wr_data;
    if (wr_c)
      next_r.ctrl_c = sess.wr_data;
    next_r.lock_latched = (r.lock_latched & ~clr_lock) | lock_event;
    next_r.meas_done = done_rise | (r.meas_done & ~clr_meas & ~meas_go);
    if (meas_go)
      next_r.measuring = 1'b1;
    else if (done_rise)
      next_r.measuring = 1'b0;
    if (done_rise)
    begin
      next_r.rate_code = ain.rate_code;
      next_r.freq = ain.freq_count;
    end
    if (rd_pulse)
      next_r.rd_byte = rd_val;
    // system reset on 1 then 0
    next_r.srst = wr_b & r.ctrl_b[B_SYS_RESET] &
      ~sess.wr_data[B_SYS_RESET];
    next_r.out.ref_band = next_r.ctrl_a[A_BAND_HI:A_BAND_LO];
    // ratio exponent, codes above eight saturate
    next_r.out.ratio_exp = next_r.ctrl_a[A_RATIO_HI:A_RATIO_LO];
    if (next_r.out.ratio_exp > RATIO_EXP_MAX)
      next_r.out.ratio_exp = RATIO_EXP_MAX;
    next_r.out.lock_to_ref = next_r.ctrl_a[A_LOCK_REF];
    next_r.out.meas_start = meas_go;
    if (next_r.ctrl_b[B_LOCK_PIN_LATCHED])
      next_r.out.lock_lost = next_r.lock_latched;
    else
      next_r.out.lock_lost = next_r.lock_lost;
    next_r.out.signal_absent = ain.signal_loss ^
      next_r.ctrl_c[C_LOSS_ACTIVE_LOW];
    // muting style; either style quiets data
    next_r.out.data_out_en = ~ain.mute;
    next_r.out.clk_out_en = ~(ain.mute &
      ~next_r.ctrl_c[C_MUTE_EITHER]);
    if (r.srst)
    begin
      next_r = CORE_RESET;
      next_r.sda_prev = sda_s;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      r <= CORE_RESET;
    else
      r <= next_r;
  end

  assign CORE_OUT = r.out;
endmodule

// ---- tb/cdr_csr_assertions.sv ----
// Port-level checks of the recovery control register bank
`timescale 1ns/1ns
module cdr_csr_checker
  import cdr_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Serial port
  input wire logic SCK,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic SADDR5,
  // Core side
  input wire core_in_s CORE_IN,
  input wire core_out_s CORE_OUT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  // ==========================================================
  // Sequences
  sequence s_muted;
    CORE_IN.mute [*6];
  endsequence
  sequence s_unmuted;
    (!CORE_IN.mute) [*8];
  endsequence
  sequence s_far_off;
    (CORE_IN.ppm_error > LOCK_LOST_PPM) [*8];
  endsequence

  // ==========================================================
  // Checks
  a_quiet_in_reset:
    assert property (disable iff (1'b0)
      !RESETN |-> (CORE_OUT == '0) && !SDA_OE)
    else $error("outputs not quiet during reset");
  a_mute_quiets:
    assert property (s_muted |-> !CORE_OUT.data_out_en)
    else $error("data output not quiet while muted");
  a_unmute_runs:
    assert property (s_unmuted |-> CORE_OUT.data_out_en)
    else $error("data output quiet without mute");
  a_style_clock:
    assert property (!CORE_OUT.clk_out_en |-> !CORE_OUT.data_out_en)
    else $error("clock quiet while data runs");
  a_lock_far:
    assert property (s_far_off |-> CORE_OUT.lock_lost)
    else $error("lock not lost beyond limit");
  a_absent_follows:
    assert property ($rose(CORE_IN.signal_loss)
      |-> ##[2:6] $changed(CORE_OUT.signal_absent))
    else $error("signal loss output did not follow");
  a_start_pulse:
    assert property ($rose(CORE_OUT.meas_start) |=> !CORE_OUT.meas_start)
    else $error("measure start longer than one cycle");
  a_ratio_capped:
    assert property (CORE_OUT.ratio_exp <= RATIO_EXP_MAX)
    else $error("ratio exponent above limit");
  a_ack_on_fall:
    assert property ($changed(SDA_OE) |-> !SCK)
    else $error("data enable moved while serial clock high");
endmodule

// ---- tb/i2c_host_model.sv ----
// Behavioural serial-port host driving clock and data
`timescale 1ns/1ns
module i2c_host_model (
  // Bus lines
  output logic sck,
  output logic sda_drv,
  input wire logic sda
);
  // Clock idles high between frames
  initial
  begin
    sck = 1'b1;
    sda_drv = 1'b1;
  end

  // ==========================================================
  // Bit and frame level
  task automatic bit_io(input logic b, output logic r);
    #8 sda_drv = b;
    #8 sck = 1'b1;
    #8 r = sda;
    #8 sck = 1'b0;
  endtask
  task automatic start;
    #8 sda_drv = 1'b1;
    #8 sck = 1'b1;
    #16 sda_drv = 1'b0;
    #16 sck = 1'b0;
  endtask
  task automatic stop;
    #8 sda_drv = 1'b0;
    #8 sck = 1'b1;
    #16 sda_drv = 1'b1;
    #16;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ai,
                         output logic [7:0] q, output logic ao);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ai, ao);
  endtask

  // ==========================================================
  // one register access per frame
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra,
                    input logic [7:0] v, output logic ack);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(ra, 1'b1, q, a1);
    byte_io(v, 1'b1, q, a2);
    stop();
    ack = !(a0 | a1 | a2);
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ra,
                    output logic [7:0] v, output logic ack);
    logic [7:0] q;
    logic a0, a1, a2, an;
    start();
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(ra, 1'b1, q, a1);
    start();
    byte_io({dev, 1'b1}, 1'b1, q, a2);
    byte_io(8'hff, 1'b1, v, an);
    stop();
    ack = !(a0 | a1 | a2);
  endtask
endmodule

// ---- tb/cdr_control_status_registers_test.sv ----
// Self-checking bench of the recovery control register bank
`timescale 1ns/1ns
module cdr_control_status_registers_test;
  import cdr_pkg::*;
  logic clk, resetn, sck, sda_drv, sda_oe, sda_out, sda;
  core_in_s core_in;
  core_out_s core_out;
  int error_cnt = 0;
  int total_checks = 0;
  int starts = 0;
  logic [3:0] ratio_tab [4] = '{4'h0, 4'h3, 4'h8, 4'hf};
  logic [7:0] freq_exp [3] = '{8'h7e, 8'h3c, 8'h7a};
  localparam logic [6:0] DEV = SLAVE_ADDR_DEFAULT;

  // Pull-up on the open-drain data line; device pulls only a driven low
  assign sda = sda_drv & ~(sda_oe & ~sda_out);

  cdr_control_status_registers u_cdr_control_status_registers (
    .CLK(clk), .RESETN(resetn), .SCK(sck), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SADDR5(1'b1),
    .CORE_IN(core_in), .CORE_OUT(core_out));
  i2c_host_model u_i2c_host_model (
    .sck(sck), .sda_drv(sda_drv), .sda(sda));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (core_out.meas_start === 1'b1)
      starts++;

  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] d, input logic [7:0] a,
                    input logic [7:0] v, input logic ea);
    logic ack;
    @(negedge clk);
    #1 u_i2c_host_model.wr(d, a, v, ack);
    chk("write ack", ack, ea);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e, input string n);
    logic [7:0] v;
    logic ack;
    @(negedge clk);
    #1 u_i2c_host_model.rd(DEV, a, v, ack);
    chk(n, {ack, v & m}, {1'b1, e});
  endtask
  task automatic settle;
    repeat (8) @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    resetn = 1'b0;
    core_in = '0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    settle();
    chk("ctrl out", core_out, 12'h003);
    wr(7'h40, ADDR_CTRL_A, 8'hc1, 1'b0);
    chk("refused", core_out.ref_band, 2'h0);
    rd(8'h05, 8'hff, 8'h00, "unmapped");
    $display("test reset finished");
    for (int i = 0; i < 4; i++)
    begin
      wr(DEV, ADDR_CTRL_A, {i[1:0], ratio_tab[i], 1'b0, i[0]}, 1'b1);
      chk("band", core_out.ref_band, i[1:0]);
      chk("ratio", core_out.ratio_exp, (ratio_tab[i] > RATIO_EXP_MAX)
        ? RATIO_EXP_MAX : ratio_tab[i]);
      chk("lock src", core_out.lock_to_ref, i[0]);
    end
    $display("test control finished");
    wr(DEV, ADDR_CTRL_A, 8'h02, 1'b1);
    chk("starts", starts, 1);
    rd(ADDR_FLAGS, 8'h04, 8'h00, "measuring");
    @(negedge clk);
    core_in.rate_code = 9'h1a5;
    core_in.freq_count = 23'h7a3c7e;
    settle();
    core_in.meas_done = 1'b1;
    settle();
    rd(ADDR_FLAGS, 8'h05, 8'h05, "done");
    rd(ADDR_RATE, 8'hff, 8'hd2, "rate");
    for (int i = 0; i < 3; i++)
      rd(i[7:0], 8'hff, freq_exp[i], "freq");
    wr(DEV, ADDR_CTRL_B, 8'h08, 1'b1);
    rd(ADDR_FLAGS, 8'h04, 8'h04, "done held");
    wr(DEV, ADDR_CTRL_B, 8'h00, 1'b1);
    rd(ADDR_FLAGS, 8'h04, 8'h00, "done clear");
    @(negedge clk);
    core_in.meas_done = 1'b0;
    settle();
    core_in.meas_done = 1'b1;
    settle();
    rd(ADDR_FLAGS, 8'h04, 8'h04, "done again");
    // A new start must drop a completed flag
    wr(DEV, ADDR_CTRL_A, 8'h02, 1'b1);
    chk("starts again", starts, 2);
    rd(ADDR_FLAGS, 8'h04, 8'h00, "restart");
    $display("test measure finished");
    @(negedge clk);
    core_in.ppm_error = LOCK_LOST_PPM;
    core_in.signal_loss = 1'b1;
    settle();
    rd(ADDR_FLAGS, 8'h38, 8'h20, "at limit");
    chk("absent", core_out.signal_absent, 1'b1);
    @(negedge clk);
    core_in.ppm_error = 16'h03e9;
    settle();
    rd(ADDR_FLAGS, 8'h38, 8'h38, "lost");
    chk("lock pin", core_out.lock_lost, 1'b1);
    @(negedge clk);
    core_in.ppm_error = RELOCK_PPM;
    settle();
    rd(ADDR_FLAGS, 8'h38, 8'h30, "relock");
    chk("lock live", core_out.lock_lost, 1'b0);
    wr(DEV, ADDR_CTRL_C, 8'h04, 1'b1);
    chk("absent low", core_out.signal_absent, 1'b0);
    wr(DEV, ADDR_CTRL_B, 8'h80, 1'b1);
    chk("lock latched", core_out.lock_lost, 1'b1);
    wr(DEV, ADDR_CTRL_B, 8'hc0, 1'b1);
    wr(DEV, ADDR_CTRL_B, 8'h80, 1'b1);
    rd(ADDR_FLAGS, 8'h38, 8'h20, "lock clear");
    chk("lock pin clear", core_out.lock_lost, 1'b0);
    $display("test flags finished");
    @(negedge clk);
    core_in.mute = 1'b1;
    settle();
    chk("mute both", {core_out.clk_out_en, core_out.data_out_en}, 2'b00);
    wr(DEV, ADDR_CTRL_C, 8'h06, 1'b1);
    chk("mute data", {core_out.clk_out_en, core_out.data_out_en}, 2'b10);
    $display("test mute finished");
    wr(DEV, ADDR_CTRL_A, 8'hc1, 1'b1);
    wr(DEV, ADDR_CTRL_B, 8'h20, 1'b1);
    chk("before reset", core_out.ref_band, 2'h3);
    wr(DEV, ADDR_CTRL_B, 8'h00, 1'b1);
    chk("soft reset", {core_out.ref_band, core_out.lock_to_ref,
      core_out.signal_absent, core_out.clk_out_en}, 5'h02);
    @(negedge clk);
    core_in.mute = 1'b0;
    settle();
    chk("unmute", core_out.data_out_en, 1'b1);
    $display("test soft reset finished");
    end_of_test();
  end

  // Hang guard
  initial
  begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule

bind cdr_control_status_registers cdr_csr_checker u_cdr_csr_checker (
  .CLK(CLK), .RESETN(RESETN), .SCK(SCK), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SADDR5(SADDR5),
  .CORE_IN(CORE_IN), .CORE_OUT(CORE_OUT));
